/* src/pin1_mux_pkg.sv */
package pin1_mux_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // printed offsets are word indices; byte address is four times that
  localparam logic [7:0]  CTRL_INDEX       = 8'h11;
  localparam logic [7:0]  STATUS_INDEX     = 8'h12;
  localparam logic [7:0]  CTRL_BYTE_ADDR   = {CTRL_INDEX[5:0], 2'b00};
  localparam logic [7:0]  STATUS_BYTE_ADDR = {STATUS_INDEX[5:0], 2'b00};
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
  localparam int          STAT_VALUE_BIT   = 0;
  localparam int          STAT_DRIVE_BIT   = 1;

  // ----------------------------------------------------------------
  // control register layout: sel 7:5, src 4:2, value 1, enable 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] src;
    logic       value;
    logic       enable;
  } ctrl_t;

  // output source codes
  typedef enum logic [2:0] {
    SRC_RX0    = 3'b000,
    SRC_RX1    = 3'b001,
    SRC_RX2    = 3'b010,
    SRC_RX3    = 3'b011,
    SRC_DEVICE = 3'b100,
    SRC_RSVD5  = 3'b101,
    SRC_TX0    = 3'b110,
    SRC_RSVD7  = 3'b111
  } src_t;

  // select codes, receive-port table
  localparam logic [2:0] RX_SEL_PIN0  = 3'b000;
  localparam logic [2:0] RX_SEL_PIN1  = 3'b001;
  localparam logic [2:0] RX_SEL_PIN3  = 3'b010;
  localparam logic [2:0] RX_SEL_LOCK  = 3'b100;
  localparam logic [2:0] RX_SEL_PASS  = 3'b101;
  localparam logic [2:0] RX_SEL_FV    = 3'b110;
  localparam logic [2:0] RX_SEL_LV    = 3'b111;
  // select codes, device-status table
  localparam logic [2:0] DEV_SEL_VAL  = 3'b000;
  localparam logic [2:0] DEV_SEL_LOCK = 3'b001;
  localparam logic [2:0] DEV_SEL_PASS = 3'b010;
  localparam logic [2:0] DEV_SEL_PAS2 = 3'b011;
  localparam logic [2:0] DEV_SEL_SYNC = 3'b100;
  // select codes, transmit-port table
  localparam logic [2:0] TX_SEL_PAND  = 3'b000;
  localparam logic [2:0] TX_SEL_POR   = 3'b001;
  localparam logic [2:0] TX_SEL_FV    = 3'b010;
  localparam logic [2:0] TX_SEL_LV    = 3'b011;
  localparam logic [2:0] TX_SEL_SYNC  = 3'b100;
  localparam logic [2:0] TX_SEL_INT   = 3'b101;

  // ----------------------------------------------------------------
  // status carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] remote_pin;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } rx_status_t;

  typedef struct packed {
    logic [3:0] port_select;
    logic       frame_valid;
    logic       line_valid;
    logic       synchronized;
    logic       interrupt;
  } tx_status_t;

endpackage : pin1_mux_pkg

/* src/pin1_output_source_mux.sv */
`timescale 1ns/1ps
`default_nettype none

module pin1_output_source_mux (
  input  wire  logic                                     sys_clk,
  input  wire  logic                                     reset_n,
  // axi4-lite slave
  input  wire  logic [pin1_mux_pkg::ADDR_W-1:0]          s_axi_awaddr,
  input  wire  logic                                     s_axi_awvalid,
  output logic                                           s_axi_awready,
  input  wire  logic [pin1_mux_pkg::DATA_W-1:0]          s_axi_wdata,
  input  wire  logic [3:0]                               s_axi_wstrb,
  input  wire  logic                                     s_axi_wvalid,
  output logic                                           s_axi_wready,
  output logic [1:0]                                     s_axi_bresp,
  output logic                                           s_axi_bvalid,
  input  wire  logic                                     s_axi_bready,
  input  wire  logic [pin1_mux_pkg::ADDR_W-1:0]          s_axi_araddr,
  input  wire  logic                                     s_axi_arvalid,
  output logic                                           s_axi_arready,
  output logic [pin1_mux_pkg::DATA_W-1:0]                s_axi_rdata,
  output logic [1:0]                                     s_axi_rresp,
  output logic                                           s_axi_rvalid,
  input  wire  logic                                     s_axi_rready,
  // status from the hub, same clock
  input  wire  pin1_mux_pkg::rx_status_t [3:0]           rx_status,
  input  wire  logic [3:0]                               rx_port_enable,
  input  wire  pin1_mux_pkg::tx_status_t                 tx_status,
  input  wire  logic                                     frame_sync_pulse,
  // pin driver
  output logic                                           pin1_out,
  output logic                                           pin1_oe_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pin1_mux_pkg::ctrl_t              ctrl;
    logic                             aw_got;
    logic                             w_got;
    logic [pin1_mux_pkg::ADDR_W-1:0]  waddr;
    logic [7:0]                       wbyte;
    logic                             wlane0;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             rvalid;
    logic [pin1_mux_pkg::DATA_W-1:0]  rdata;
    logic [1:0]                       rresp;
    logic                             pin_value;
    logic                             pin_drive;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word match, ignoring the byte offset inside the word
  function automatic logic addr_hits(
    input logic [pin1_mux_pkg::ADDR_W-1:0] addr,
    input logic [pin1_mux_pkg::ADDR_W-1:0] base
  );
    addr_hits = (addr[pin1_mux_pkg::ADDR_W-1:2] == base[pin1_mux_pkg::ADDR_W-1:2]);
  endfunction : addr_hits

  // AND over the masked ports; an empty mask gives 1
  function automatic logic and_masked(
    input logic [3:0] bits,
    input logic [3:0] mask
  );
    and_masked = &(bits | ~mask);
  endfunction : and_masked

  // ----------------------------------------------------------------
  // output multiplexer
  // ----------------------------------------------------------------
  function automatic logic pin_mux(
    input pin1_mux_pkg::ctrl_t             c,
    input pin1_mux_pkg::rx_status_t [3:0]  rx,
    input logic [3:0]                      rx_en,
    input pin1_mux_pkg::tx_status_t        tx,
    input logic                            fsync
  );
    pin1_mux_pkg::rx_status_t port;
    logic [3:0]               locks;
    logic [3:0]               passes;
    logic                     result;
    port   = rx[c.src[1:0]];
    locks  = {rx[3].lock, rx[2].lock, rx[1].lock, rx[0].lock};
    passes = {rx[3].pass, rx[2].pass, rx[1].pass, rx[0].pass};
    result = 1'b0;
    // reserved source and select codes all give a quiet low
    case (pin1_mux_pkg::src_t'(c.src))
      pin1_mux_pkg::SRC_RX0,
      pin1_mux_pkg::SRC_RX1,
      pin1_mux_pkg::SRC_RX2,
      pin1_mux_pkg::SRC_RX3: begin
        case (c.sel)
          pin1_mux_pkg::RX_SEL_PIN0: result = port.remote_pin[0];
          pin1_mux_pkg::RX_SEL_PIN1: result = port.remote_pin[1];
          pin1_mux_pkg::RX_SEL_PIN3: result = port.remote_pin[3];
          pin1_mux_pkg::RX_SEL_LOCK: result = port.lock;
          pin1_mux_pkg::RX_SEL_PASS: result = port.pass;
          pin1_mux_pkg::RX_SEL_FV:   result = port.frame_valid;
          pin1_mux_pkg::RX_SEL_LV:   result = port.line_valid;
          default:                   result = 1'b0;
        endcase
      end
      pin1_mux_pkg::SRC_DEVICE: begin
        case (c.sel)
          pin1_mux_pkg::DEV_SEL_VAL:  result = c.value;
          pin1_mux_pkg::DEV_SEL_LOCK: result = |(locks & rx_en);
          pin1_mux_pkg::DEV_SEL_PASS,
          pin1_mux_pkg::DEV_SEL_PAS2: result = and_masked(passes, rx_en);
          pin1_mux_pkg::DEV_SEL_SYNC: result = fsync;
          default:                    result = 1'b0;
        endcase
      end
      pin1_mux_pkg::SRC_TX0: begin
        case (c.sel)
          pin1_mux_pkg::TX_SEL_PAND: result = and_masked(passes, tx.port_select);
          pin1_mux_pkg::TX_SEL_POR:  result = |(passes & tx.port_select);
          pin1_mux_pkg::TX_SEL_FV:   result = tx.frame_valid;
          pin1_mux_pkg::TX_SEL_LV:   result = tx.line_valid;
          pin1_mux_pkg::TX_SEL_SYNC: result = tx.synchronized;
          pin1_mux_pkg::TX_SEL_INT:  result = tx.interrupt;
          default:                   result = 1'b0;
        endcase
      end
      default: result = 1'b0;
    endcase
    pin_mux = result;
  endfunction : pin_mux

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // one write at a time: address and data are held until the response
  // is taken, so a second write cannot overtake the first
  assign s_axi_awready = !state_q.aw_got && !state_q.bvalid;
  assign s_axi_wready  = !state_q.w_got && !state_q.bvalid;
  assign s_axi_arready = !state_q.rvalid;
  assign s_axi_bvalid  = state_q.bvalid;
  assign s_axi_bresp   = state_q.bresp;
  assign s_axi_rvalid  = state_q.rvalid;
  assign s_axi_rdata   = state_q.rdata;
  assign s_axi_rresp   = state_q.rresp;

  // pin driver, both from flip-flops
  assign pin1_out  = state_q.pin_value;
  assign pin1_oe_n = !state_q.pin_drive;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic mux_value;
    state_d   = state_q;
    mux_value = pin_mux(state_q.ctrl, rx_status, rx_port_enable, tx_status,
                        frame_sync_pulse);

    // capture write address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_d.aw_got = 1'b1;
      state_d.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_d.w_got  = 1'b1;
      state_d.wbyte  = s_axi_wdata[7:0];
      state_d.wlane0 = s_axi_wstrb[0];
    end

    // commit once both halves are held; unmapped words get slverr
    if (state_d.aw_got && state_d.w_got && !state_q.bvalid) begin
      state_d.aw_got = 1'b0;
      state_d.w_got  = 1'b0;
      state_d.bvalid = 1'b1;
      if (addr_hits(state_d.waddr, pin1_mux_pkg::CTRL_BYTE_ADDR)) begin
        state_d.bresp = pin1_mux_pkg::RESP_OKAY;
        if (state_d.wlane0) begin
          state_d.ctrl = pin1_mux_pkg::ctrl_t'(state_d.wbyte);
        end
      end else if (addr_hits(state_d.waddr, pin1_mux_pkg::STATUS_BYTE_ADDR)) begin
        state_d.bresp = pin1_mux_pkg::RESP_OKAY; // status is read-only, write ignored
      end else begin
        state_d.bresp = pin1_mux_pkg::RESP_SLVERR;
      end
    end else if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end

    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      state_d.rvalid = 1'b1;
      state_d.rdata  = '0;
      state_d.rresp  = pin1_mux_pkg::RESP_OKAY;
      if (addr_hits(s_axi_araddr, pin1_mux_pkg::CTRL_BYTE_ADDR)) begin
        state_d.rdata[7:0] = state_q.ctrl;
      end else if (addr_hits(s_axi_araddr, pin1_mux_pkg::STATUS_BYTE_ADDR)) begin
        state_d.rdata[pin1_mux_pkg::STAT_VALUE_BIT] = state_q.pin_value;
        state_d.rdata[pin1_mux_pkg::STAT_DRIVE_BIT] = state_q.pin_drive;
      end else begin
        state_d.rresp = pin1_mux_pkg::RESP_SLVERR;
      end
    end else if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end

    // driver: value forced low and enable off while disabled, so a
    // stale mux result never reaches the pin
    state_d.pin_drive = state_q.ctrl.enable;
    state_d.pin_value = state_q.ctrl.enable ? mux_value : 1'b0;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all fields clear on reset, leaving the pin undriven
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= '0;
      state_q.ctrl <= pin1_mux_pkg::ctrl_t'(pin1_mux_pkg::CTRL_RESET);
    end else begin
      state_q <= state_d;
    end
  end

endmodule : pin1_output_source_mux

`default_nettype wire

/* bench/pin_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sensor_model (
  input  wire logic pin1_out,
  input  wire logic pin1_oe_n,
  output logic      pin_seen
);
  // a released pin sits on its pull-down, never on a stale driven value
  assign pin_seen = pin1_oe_n ? 1'b0 : pin1_out;
endmodule : pin_sensor_model

`default_nettype wire

/* bench/pin1_mux_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module pin1_mux_checker (
  input wire logic                           sys_clk,
  input wire logic                           reset_n,
  input wire logic [7:0]                     s_axi_awaddr,
  input wire logic                           s_axi_awvalid,
  input wire logic                           s_axi_awready,
  input wire logic [31:0]                    s_axi_wdata,
  input wire logic [3:0]                     s_axi_wstrb,
  input wire logic                           s_axi_wvalid,
  input wire logic                           s_axi_wready,
  input wire pin1_mux_pkg::rx_status_t [3:0] rx_status,
  input wire logic [3:0]                     rx_port_enable,
  input wire pin1_mux_pkg::tx_status_t       tx_status,
  input wire logic                           frame_sync_pulse,
  input wire logic                           pin1_out,
  input wire logic                           pin1_oe_n
);
  // ------
  // shadow of the control register
  // ------
  pin1_mux_pkg::ctrl_t sh_q;
  logic [3:0]          lock_v;
  logic [3:0]          pass_v;
  // only paired address/data beats are tracked; the bench never splits them
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr[7:2] == 6'h11 && s_axi_wstrb[0]) begin
      sh_q <= s_axi_wdata[7:0];
    end
  end
  // per-port flags gathered for the two or selections
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lock_v[i] = rx_status[i].lock;
      pass_v[i] = rx_status[i].pass;
    end
  end
  // ------
  // pin properties: one cycle from control and status to the pin
  // ------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_pick(logic [2:0] s, logic [2:0] c);
    $past(sh_q.enable && sh_q.src == s && sh_q.sel == c);
  endsequence
  property p_off; !$past(sh_q.enable) |-> pin1_oe_n && !pin1_out; endproperty
  property p_on; $past(sh_q.enable) |-> !pin1_oe_n; endproperty
  property p_val; s_pick(3'b100, 3'b000) |-> pin1_out == $past(sh_q.value); endproperty
  property p_rx_pin;
    $past(sh_q.enable && !sh_q.src[2] && sh_q.sel == 3'b001)
      |-> pin1_out == $past(rx_status[sh_q.src[1:0]].remote_pin[1]);
  endproperty
  property p_rx_lv;
    $past(sh_q.enable && !sh_q.src[2] && sh_q.sel == 3'b111)
      |-> pin1_out == $past(rx_status[sh_q.src[1:0]].line_valid);
  endproperty
  property p_dev_or;
    s_pick(3'b100, 3'b001) |-> pin1_out == $past(|(lock_v & rx_port_enable));
  endproperty
  property p_tx_or;
    s_pick(3'b110, 3'b001) |-> pin1_out == $past(|(pass_v & tx_status.port_select));
  endproperty
  property p_sync; s_pick(3'b100, 3'b100) |-> pin1_out == $past(frame_sync_pulse); endproperty
  property p_tx_int; s_pick(3'b110, 3'b101) |-> pin1_out == $past(tx_status.interrupt); endproperty
  property p_rsvd; $past(sh_q.src == 3'b101 || sh_q.src == 3'b111) |-> !pin1_out; endproperty
  a_off: assert property (p_off) else $error("pin driven while disabled");
  a_on: assert property (p_on) else $error("pin not driven while enabled");
  a_val: assert property (p_val) else $error("register value not on pin");
  a_rx_pin: assert property (p_rx_pin) else $error("remote pin 1 wrong");
  a_rx_lv: assert property (p_rx_lv) else $error("port line valid wrong");
  a_dev_or: assert property (p_dev_or) else $error("lock or wrong");
  a_tx_or: assert property (p_tx_or) else $error("pass or wrong");
  a_sync: assert property (p_sync) else $error("frame sync wrong");
  a_tx_int: assert property (p_tx_int) else $error("tx interrupt wrong");
  a_rsvd: assert property (p_rsvd) else $error("reserved source drives 1");
endmodule : pin1_mux_checker

bind pin1_output_source_mux pin1_mux_checker u_pin1_mux_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .rx_status(rx_status), .rx_port_enable(rx_port_enable), .tx_status(tx_status),
  .frame_sync_pulse(frame_sync_pulse), .pin1_out(pin1_out), .pin1_oe_n(pin1_oe_n));

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                           sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic                           awready, wready, bvalid, arready, rvalid, fsync;
  logic                           pin1_out, pin1_oe_n, pin_seen, dn;
  logic [7:0]                     awaddr, araddr;
  logic [31:0]                    wdata, rdata, got;
  logic [3:0]                     wstrb, rx_en;
  logic [1:0]                     bresp, rresp, resp;
  pin1_mux_pkg::rx_status_t [3:0] rx_status;
  pin1_mux_pkg::tx_status_t       tx_status;
  int                             error_cnt, n_compared, n;
  // rows: port enables, control byte, expected pin value
  logic [15:0] rows [25] = '{16'h9011, 16'h9251, 16'h9491, 16'h98d1, 16'h9a10, 16'h9c11,
    16'h9e51, 16'h9131, 16'h9110, 16'h6310, 16'h9311, 16'h8511, 16'h9510, 16'h9911,
    16'h9b10, 16'h9190, 16'h9391, 16'h9591, 16'h9790, 16'h9991, 16'h9b91, 16'h9f90,
    16'h9350, 16'h99d0, 16'h9120};

  pin1_output_source_mux u_pin1_output_source_mux (
    .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_status(rx_status), .rx_port_enable(rx_en), .tx_status(tx_status),
    .frame_sync_pulse(fsync), .pin1_out(pin1_out), .pin1_oe_n(pin1_oe_n));
  pin_sensor_model u_pin_sensor_model (
    .pin1_out(pin1_out), .pin1_oe_n(pin1_oe_n), .pin_seen(pin_seen));

  // ------
  // bus tasks and report
  // ------
  task automatic give_verdict;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  // the bound only cuts a hang; the slave's answer time is never assumed
  // handshakes are judged on settled values at the falling edge, acted on at the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok, w_ok, b_ok;
    @(posedge sys_clk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'b111;
    dn = 0;
    for (n = 0; n < 50 && !dn; n++) begin
      @(negedge sys_clk);
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      b_ok  = bvalid && bready;
      if (b_ok) resp = bresp;
      @(posedge sys_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) begin
        bready <= 1'b0;
        dn = 1;
      end
    end
    if (!dn) begin
      error_cnt++;
      give_verdict();
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    @(posedge sys_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    dn = 0;
    for (n = 0; n < 50 && !dn; n++) begin
      @(negedge sys_clk);
      ar_ok = arvalid && arready;
      r_ok  = rvalid && rready;
      if (r_ok) {got, resp} = {rdata, rresp};
      @(posedge sys_clk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) begin
        rready <= 1'b0;
        dn = 1;
      end
    end
    if (!dn) begin
      error_cnt++;
      give_verdict();
    end
  endtask : axi_rd

  // ------
  // stimulus
  // ------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, rx_en, error_cnt, n_compared} = '0;
    rx_status = 32'h4f80_a51a;
    tx_status = 8'h3b;
    fsync = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    axi_rd(pin1_mux_pkg::CTRL_BYTE_ADDR);
    check(got, 32'h0000_0000);
    check(32'({pin1_oe_n, pin1_out}), 32'h0000_0002);
    // every source and every named select but DEV_SEL_PAS2, each followed two edges later at the pin
    foreach (rows[i]) begin
      @(posedge sys_clk);
      rx_en <= rows[i][15:12];
      axi_wr(pin1_mux_pkg::CTRL_BYTE_ADDR, 32'(rows[i][11:4]), 4'hf);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check(32'({pin1_oe_n, pin1_out, pin_seen}), 32'({~rows[i][4], {2{rows[i][0]}}}));
    end
    // a write without lane 0 leaves the register alone, then readback
    axi_wr(pin1_mux_pkg::CTRL_BYTE_ADDR, 32'h0000_00ff, 4'he);
    check(32'(resp), 32'(pin1_mux_pkg::RESP_OKAY));
    axi_rd(pin1_mux_pkg::CTRL_BYTE_ADDR);
    check(got, 32'h0000_0012);
    axi_rd(8'h80);
    check({got[29:0], resp}, 32'(pin1_mux_pkg::RESP_SLVERR));
    // reset in mid-run drops the driver at once
    axi_wr(pin1_mux_pkg::CTRL_BYTE_ADDR, 32'h0000_0013, 4'hf);
    // status word: bit 0 pin value, bit 1 driver on
    axi_rd(pin1_mux_pkg::STATUS_BYTE_ADDR);
    check(got, 32'h0000_0003);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(negedge sys_clk);
    check(32'({pin1_oe_n, pin1_out}), 32'h0000_0002);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    axi_rd(pin1_mux_pkg::CTRL_BYTE_ADDR);
    check(got, 32'h0000_0000);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
